// File: src/tcoc_defines.svh
`ifndef TCOC_DEFINES_SVH
`define TCOC_DEFINES_SVH

`define TCOC_ADDR_CTRLA 3'h0
`define TCOC_ADDR_CTRLB 3'h1
`define TCOC_ADDR_COUNT 3'h2
`define TCOC_ADDR_CMPA 3'h3
`define TCOC_ADDR_CMPB 3'h4
`define TCOC_ADDR_CMPC 3'h5
`define TCOC_ADDR_CAPT 3'h6
`define TCOC_ADDR_FLAGS 3'h7

`define TCOC_CTRLA_RST 8'h00
`define TCOC_CTRLB_RST 8'h00
`define TCOC_CTRLB_WMASK 8'hdf
`define TCOC_WGM_HI_MSB 4
`define TCOC_WGM_HI_LSB 3
`define TCOC_CS_MSB 2
`define TCOC_COMA_MSB 7
`define TCOC_COMB_MSB 5
`define TCOC_COMC_MSB 3
`define TCOC_WGM_LO_MSB 1

`define TCOC_DIV8_LIM 10'h007
`define TCOC_DIV64_LIM 10'h03f
`define TCOC_DIV256_LIM 10'h0ff
`define TCOC_DIV1024_LIM 10'h3ff

`define TCOC_TOP_MAX 16'hffff
`define TCOC_TOP_8 16'h00ff
`define TCOC_TOP_9 16'h01ff
`define TCOC_TOP_10 16'h03ff

`endif

// File: src/tcoc_pkg.sv
package tcoc_pkg;
	typedef enum logic [2:0] {
		TCOC_NORMAL,
		TCOC_CTC,
		TCOC_FAST,
		TCOC_PC,
		TCOC_PFC,
		TCOC_RSVD
	} tcoc_cls_t;
endpackage

// File: src/tcoc_top.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "tcoc_defines.svh"
// Operation
// [RQ1] The counter runs on ref_clk alone and the prescaled tick is only a clock enable.
// [RQ2] In phase and frequency correct mode the buffered compare values load at BOTTOM.
// [RQ3] Modes that flag the wrap at BOTTOM set it on the same tick as BOTTOM itself.
// [RQ4] A channel whose two-bit action field is nonzero takes over its pin.
// [RQ5] Software must make each compare pin an output before the waveform shows.
// [RQ6] Action codes decode by mode class: non-PWM, fast PWM or dual-slope PWM.
// [RQ7] Non-PWM: 00 disconnected, 01 toggles, 10 clears, 11 sets on compare match.
// [RQ8] Fast PWM code 01 toggles channel A only, and only in modes 14 and 15.
// [RQ9] Fast PWM code 10 clears on match and sets at TOP; code 11 does the inverse.
// [RQ10] Fast PWM with compare equal to TOP and upper code bit set ignores the match.
// [RQ11] Control A holds actions A, B, C in 7:6, 5:4, 3:2 and mode bits 1:0, reset 0.
// [RQ12] Dual-slope code 10 clears on up-count match and sets on down; 11 inverts.
// [RQ13] The mode is control A bits 1:0 joined with two upper bits in control B.
module tcoc_top
	import tcoc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic chan_a_wave_out,
	output logic chan_b_wave_out,
	output logic chan_c_wave_out,
	output logic chan_a_pin_override,
	output logic chan_b_pin_override,
	output logic chan_c_pin_override,
	output logic counter_wrap_flag,
	output logic [2:0] compare_match_flag
);

	logic [7:0] timer1_output_mode_control, timer_control_b;
	logic [15:0] count_value, capture_top_r, rdata_r, top, count_nxt;
	logic [15:0] cmp_buf_r [3];
	logic [15:0] compare_value [3];
	logic [9:0] pre_r, pre_lim;
	logic [3:0] waveform_mode_select;
	logic [2:0] match_flag_r, wave_r, ovr_r, match;
	logic timer_tick_enable, up_r, wrap_r, pre_run, at_top, at_bot, up_eff;
	logic load_evt, wrap_evt, tog_a;
	tcoc_cls_t cls;

	function automatic tcoc_cls_t mode_class(input logic [3:0] m);
		tcoc_cls_t c;
		c = TCOC_RSVD;
		unique case (m)
			4'h0: c = TCOC_NORMAL;
			4'h4, 4'hc: c = TCOC_CTC;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: c = TCOC_FAST;
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: c = TCOC_PC;
			4'h8, 4'h9: c = TCOC_PFC;
			4'hd: c = TCOC_RSVD;
		endcase
		return c;
	endfunction
	// One decoder serves all three channels so their behaviour cannot drift apart
	function automatic logic wave_nxt(input logic cur, input logic [1:0] code,
			input tcoc_cls_t c, input logic hit, input logic tp, input logic cmp_top,
			input logic up, input logic tog_ok);
		logic r;
		r = cur;
		unique case (c)
			TCOC_NORMAL, TCOC_CTC: begin
				if (hit && code != 2'b00) begin
					r = (code == 2'b01) ? ~cur : code[0]; // RQ7
				end
			end
			TCOC_FAST: begin
				if (code[1]) begin
					if (tp) begin
						r = ~code[0]; // RQ9
					end else if (hit && !cmp_top) begin
						r = code[0]; // RQ10
					end
				end else if (code[0] && hit && tog_ok) begin
					r = ~cur; // RQ8
				end
			end
			TCOC_PC, TCOC_PFC: begin
				if (hit && code[1]) begin
					r = up ? code[0] : ~code[0]; // RQ12
				end else if (hit && code[0] && tog_ok) begin
					r = ~cur;
				end
			end
			TCOC_RSVD: r = cur;
		endcase
		return r;
	endfunction
	function automatic logic wr_at(input logic [2:0] a);
		return reg_wr && reg_addr == a;
	endfunction
	assign waveform_mode_select = {timer_control_b[`TCOC_WGM_HI_MSB:`TCOC_WGM_HI_LSB],
		timer1_output_mode_control[`TCOC_WGM_LO_MSB:0]}; // RQ13
	assign cls = mode_class(waveform_mode_select); // RQ6
	assign tog_a = (waveform_mode_select[3:1] == 3'b111) || (waveform_mode_select[3:2] == 2'b10);
	always_comb begin
		unique case (waveform_mode_select)
			4'h0, 4'hd: top = `TCOC_TOP_MAX;
			4'h1, 4'h5: top = `TCOC_TOP_8;
			4'h2, 4'h6: top = `TCOC_TOP_9;
			4'h3, 4'h7: top = `TCOC_TOP_10;
			4'h4, 4'h9, 4'hb, 4'hf: top = compare_value[0];
			4'h8, 4'ha, 4'hc, 4'he: top = capture_top_r;
		endcase
	end
	always_comb begin
		pre_run = 1'b1;
		unique case (timer_control_b[`TCOC_CS_MSB:0])
			3'h1: pre_lim = 10'h000;
			3'h2: pre_lim = `TCOC_DIV8_LIM;
			3'h3: pre_lim = `TCOC_DIV64_LIM;
			3'h4: pre_lim = `TCOC_DIV256_LIM;
			3'h5: pre_lim = `TCOC_DIV1024_LIM;
			default: begin
				pre_lim = 10'h000;
				pre_run = 1'b0;
			end
		endcase
	end
	// Tick is a one-cycle enable, never a clock, so everything stays on ref_clk
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pre_r <= 10'h000;
			timer_tick_enable <= 1'b0;
		end else begin
			timer_tick_enable <= pre_run && pre_r >= pre_lim; // RQ1
			pre_r <= (!pre_run || pre_r >= pre_lim) ? 10'h000 : pre_r + 10'h001;
		end
	end
	assign at_top = count_value == top;
	assign at_bot = count_value == 16'h0000;
	assign up_eff = at_bot ? 1'b1 : (at_top ? 1'b0 : up_r);
	always_comb begin
		count_nxt = (count_value == top) ? 16'h0000 : count_value + 16'h0001;
		if (cls == TCOC_PC || cls == TCOC_PFC) begin
			count_nxt = up_eff ? count_value + 16'h0001 : count_value - 16'h0001;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			count_value <= 16'h0000;
			up_r <= 1'b1;
		end else if (wr_at(`TCOC_ADDR_COUNT)) begin
			count_value <= reg_wdata;
		end else if (timer_tick_enable) begin
			count_value <= count_nxt; // RQ1
			up_r <= up_eff;
		end
	end
	always_comb begin
		load_evt = 1'b0;
		wrap_evt = 1'b0;
		unique case (cls)
			TCOC_NORMAL, TCOC_CTC, TCOC_RSVD: wrap_evt = count_value == `TCOC_TOP_MAX;
			TCOC_FAST: begin
				load_evt = at_top;
				wrap_evt = at_top;
			end
			TCOC_PC: begin
				load_evt = at_top;
				wrap_evt = at_bot;
			end
			TCOC_PFC: begin
				load_evt = at_bot; // RQ2
				wrap_evt = at_bot; // RQ3
			end
		endcase
		load_evt = load_evt && timer_tick_enable;
		wrap_evt = wrap_evt && timer_tick_enable;
	end
	// Immediate modes bypass the buffer; buffered modes wait for the load point
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int i = 0; i < 3; i++) begin
				cmp_buf_r[i] <= 16'h0000;
				compare_value[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_at(3'(`TCOC_ADDR_CMPA + i))) begin
					cmp_buf_r[i] <= reg_wdata;
				end
				if (wr_at(3'(`TCOC_ADDR_CMPA + i)) && (cls == TCOC_NORMAL || cls == TCOC_CTC)) begin
					compare_value[i] <= reg_wdata;
				end else if (load_evt) begin
					compare_value[i] <= cmp_buf_r[i]; // RQ2
				end
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			match[i] = timer_tick_enable && count_value == compare_value[i];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wave_r <= 3'h0;
		end else if (timer_tick_enable) begin
			for (int i = 0; i < 3; i++) begin
				wave_r[i] <= wave_nxt(wave_r[i], timer1_output_mode_control[7 - 2 * i -: 2],
					cls, match[i], at_top, compare_value[i] == top, up_eff,
					(i == 0) && tog_a); // RQ6
			end
		end
	end
	// The pin driver itself still needs its direction bit set by software
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ovr_r <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				ovr_r[i] <= |timer1_output_mode_control[7 - 2 * i -: 2]; // RQ4
			end
		end
	end
	// Set beats a same-cycle clear so no event is lost
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wrap_r <= 1'b0;
			match_flag_r <= 3'h0;
		end else begin
			wrap_r <= (wrap_r && !(wr_at(`TCOC_ADDR_FLAGS) && reg_wdata[0])) || wrap_evt; // RQ3
			match_flag_r <= (match_flag_r & ~({3{wr_at(`TCOC_ADDR_FLAGS)}} & reg_wdata[3:1]))
				| match;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			timer1_output_mode_control <= `TCOC_CTRLA_RST;
			timer_control_b <= `TCOC_CTRLB_RST;
			capture_top_r <= 16'h0000;
		end else begin
			if (wr_at(`TCOC_ADDR_CTRLA)) begin
				timer1_output_mode_control <= reg_wdata[7:0]; // RQ11
			end
			if (wr_at(`TCOC_ADDR_CTRLB)) begin
				timer_control_b <= reg_wdata[7:0] & `TCOC_CTRLB_WMASK;
			end
			if (wr_at(`TCOC_ADDR_CAPT)) begin
				capture_top_r <= reg_wdata;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`TCOC_ADDR_CTRLA: rdata_r <= {8'h00, timer1_output_mode_control}; // RQ11
				`TCOC_ADDR_CTRLB: rdata_r <= {8'h00, timer_control_b};
				`TCOC_ADDR_COUNT: rdata_r <= count_value;
				`TCOC_ADDR_CMPA: rdata_r <= cmp_buf_r[0];
				`TCOC_ADDR_CMPB: rdata_r <= cmp_buf_r[1];
				`TCOC_ADDR_CMPC: rdata_r <= cmp_buf_r[2];
				`TCOC_ADDR_CAPT: rdata_r <= capture_top_r;
				`TCOC_ADDR_FLAGS: rdata_r <= {12'h000, match_flag_r, wrap_r};
			endcase
		end else begin
			rdata_r <= 16'h0000;
		end
	end
	assign reg_rdata = rdata_r;
	assign chan_a_wave_out = wave_r[0];
	assign chan_b_wave_out = wave_r[1];
	assign chan_c_wave_out = wave_r[2];
	assign chan_a_pin_override = ovr_r[0];
	assign chan_b_pin_override = ovr_r[1];
	assign chan_c_pin_override = ovr_r[2];
	assign counter_wrap_flag = wrap_r;
	assign compare_match_flag = match_flag_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_tick_only;
		!$stable(count_value) && !$past(wr_at(`TCOC_ADDR_COUNT)) |-> $past(timer_tick_enable);
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("count moved without tick"); // RQ1
	property p_pfc_load;
		timer_tick_enable && cls == TCOC_PFC && at_bot ##1 !$past(wr_at(`TCOC_ADDR_CMPB))
			|-> compare_value[1] == $past(cmp_buf_r[1]);
	endproperty
	a_pfc_load: assert property (p_pfc_load) else $error("no load at bottom"); // RQ2
	property p_wrap_bot;
		timer_tick_enable && cls == TCOC_PFC && at_bot |=> counter_wrap_flag;
	endproperty
	a_wrap_bot: assert property (p_wrap_bot) else $error("wrap flag missed at bottom"); // RQ3
	property p_override;
		$changed(timer1_output_mode_control[5:4])
			|=> chan_b_pin_override == |$past(timer1_output_mode_control[5:4]);
	endproperty
	a_override: assert property (p_override) else $error("pin override wrong"); // RQ4
	property p_class;
		timer_control_b[4:3] == 2'b11 && timer1_output_mode_control[1:0] == 2'b10
			|-> cls == TCOC_FAST;
	endproperty
	a_class: assert property (p_class) else $error("mode class wrong"); // RQ6
	property p_np_clear;
		cls == TCOC_CTC && timer1_output_mode_control[7:6] == 2'b10 && match[0]
			|=> !chan_a_wave_out;
	endproperty
	a_np_clear: assert property (p_np_clear) else $error("non-PWM clear failed"); // RQ7
	property p_fast_b_off;
		cls == TCOC_FAST && timer1_output_mode_control[5:4] == 2'b01 |=> $stable(chan_b_wave_out);
	endproperty
	a_fast_b_off: assert property (p_fast_b_off) else $error("channel B toggled"); // RQ8
	property p_fast_top;
		cls == TCOC_FAST && timer1_output_mode_control[5:4] == 2'b10
			&& timer_tick_enable && at_top |=> chan_b_wave_out;
	endproperty
	a_fast_top: assert property (p_fast_top) else $error("fast set at TOP missed"); // RQ9 RQ10
	property p_ctrla_read;
		reg_rd && reg_addr == `TCOC_ADDR_CTRLA |=> reg_rdata == {8'h00, $past(timer1_output_mode_control)};
	endproperty
	a_ctrla_read: assert property (p_ctrla_read) else $error("control A read wrong"); // RQ11
	property p_pc_up;
		cls == TCOC_PC && timer1_output_mode_control[3:2] == 2'b10 && match[2] && up_eff
			&& !at_top |=> !chan_c_wave_out;
	endproperty
	a_pc_up: assert property (p_pc_up) else $error("dual-slope up clear failed"); // RQ12

	c_fast: cover property (cls == TCOC_FAST && match[0] ##1 chan_a_wave_out);
	c_pfc_wrap: cover property (cls == TCOC_PFC && wrap_evt);
	c_toggle: cover property (tog_a && match[0] ##1 $changed(chan_a_wave_out));
endmodule

// File: dv/tcoc_pin_model.sv
`timescale 1ns/1ps
// Port pins behind the compare outputs; a pin with its driver off floats to the pull-up
module tcoc_pin_model (
	input wire logic [2:0] wave,
	input wire logic [2:0] over,
	input wire logic [2:0] dir_out,
	input wire logic [2:0] port_data,
	output logic [2:0] pin
);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (!dir_out[i])
				pin[i] = 1'b1;
			else if (over[i])
				pin[i] = wave[i];
			else
				pin[i] = port_data[i];
		end
	end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	wire [2:0] wave;
	wire [2:0] over;
	logic [2:0] mflag;
	logic [2:0] pin;
	logic [2:0] dir_out = 3'h0;
	logic [2:0] port_data = 3'h0;
	logic wrap;
	logic [15:0] d;
	logic a1;
	int n_mismatch = 0;
	int n_checks = 0;
	int n;

	tcoc_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.chan_a_wave_out(wave[0]), .chan_b_wave_out(wave[1]), .chan_c_wave_out(wave[2]),
		.chan_a_pin_override(over[0]), .chan_b_pin_override(over[1]),
		.chan_c_pin_override(over[2]), .counter_wrap_flag(wrap), .compare_match_flag(mflag));
	tcoc_pin_model pins_u (.wave(wave), .over(over), .dir_out(dir_out),
		.port_data(port_data), .pin(pin));

	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic rst();
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
	endtask

	// Flag order follows the flags register: wrap in bit 0, matches A..C above
	task automatic wfl(input logic [3:0] m, output int k);
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (!(|({mflag, wrap} & m)) && k < 2000);
		if (k >= 2000)
			chk(16'h0001, 16'h0000);
	endtask

	task automatic t_regs();
		rst();
		rd(3'h0, d);
		chk(d, 16'h0000);
		wr(3'h0, 16'hffff);
		rd(3'h0, d);
		chk(d, 16'h00ff);
		wr(3'h0, 16'h005a);
		rd(3'h0, d);
		chk(d, 16'h005a);
		$display("test regs done");
	endtask

	task automatic t_ovr();
		for (int i = 0; i < 4; i++) begin
			wr(3'h0, {8'h00, i[1:0], i[1:0], i[1:0], 2'b00});
			@(posedge ref_clk);
			#1;
			chk({13'h0, over}, (i == 0) ? 16'h0000 : 16'h0007);
		end
		wr(3'h0, 16'h0060);
		@(posedge ref_clk);
		#1;
		chk({13'h0, over}, 16'h0003);
		chk({13'h0, pin}, 16'h0007);
		$display("test override done");
	endtask

	task automatic t_ctc();
		rst();
		dir_out <= 3'h7;
		wr(3'h3, 16'h0005);
		wr(3'h4, 16'h0005);
		wr(3'h5, 16'h0005);
		wr(3'h0, 16'h00e4);
		wr(3'h1, 16'h0009);
		wfl(4'h2, n);
		chk({13'h0, wave}, 16'h0005);
		chk({13'h0, pin}, 16'h0005);
		// Codes chosen idempotent so a match during the rewrite cannot blur the result
		wr(3'h0, 16'h00b8);
		wr(3'h7, 16'h000f);
		wfl(4'h2, n);
		chk({13'h0, wave}, 16'h0002);
		rd(3'h7, d);
		chk(d, 16'h000e);
		$display("test ctc done");
	endtask

	task automatic t_fast();
		rst();
		wr(3'h4, 16'h0003);
		wr(3'h5, 16'h00ff);
		wr(3'h0, 16'h006d);
		wr(3'h1, 16'h0009);
		wfl(4'h1, n);
		chk({13'h0, wave}, 16'h0002);
		wr(3'h7, 16'h000f);
		wfl(4'h4, n);
		chk({13'h0, wave}, 16'h0000);
		wr(3'h7, 16'h000f);
		wfl(4'h1, n);
		chk({13'h0, wave}, 16'h0002);
		$display("test fast done");
	endtask

	task automatic t_fast14();
		rst();
		wr(3'h6, 16'h0010);
		wr(3'h3, 16'h0004);
		wr(3'h0, 16'h0056);
		wr(3'h1, 16'h0019);
		wfl(4'h1, n);
		wr(3'h7, 16'h000f);
		wfl(4'h2, n);
		a1 = wave[0];
		wr(3'h7, 16'h000f);
		wfl(4'h2, n);
		chk({15'h0, wave[0]}, {15'h0, ~a1});
		chk({14'h0, wave[2:1]}, 16'h0000);
		$display("test fast14 done");
	endtask

	task automatic t_pfc();
		rst();
		wr(3'h6, 16'h0008);
		wr(3'h4, 16'h0003);
		wr(3'h0, 16'h0020);
		wr(3'h1, 16'h0011);
		wfl(4'h4, n);
		chk({15'h0, wave[1]}, 16'h0000);
		wr(3'h7, 16'h000f);
		wr(3'h4, 16'h0006);
		wfl(4'h4, n);
		chk({15'h0, n > 4}, 16'h0001);
		chk({15'h0, wave[1]}, 16'h0001);
		wfl(4'h1, n);
		chk(n[15:0], 16'h0003);
		rd(3'h7, d);
		chk(d, 16'h000f);
		$display("test pfc done");
	endtask

	// Phase correct loads at TOP, so the new compare already hits on the way down
	task automatic t_pc();
		rst();
		wr(3'h6, 16'h0008);
		wr(3'h5, 16'h0003);
		wr(3'h0, 16'h000a);
		wr(3'h1, 16'h0011);
		wfl(4'h8, n);
		chk({15'h0, wave[2]}, 16'h0000);
		wr(3'h7, 16'h000f);
		wr(3'h5, 16'h0006);
		wfl(4'h8, n);
		chk(n[15:0], 16'h0003);
		chk({15'h0, wave[2]}, 16'h0001);
		$display("test pc done");
	endtask

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		t_regs();
		t_ovr();
		t_ctc();
		t_fast();
		t_fast14();
		t_pfc();
		t_pc();
		end_sim();
	end

	// The tests need under a thousand cycles; this 20000-cycle limit allows ample margin
	initial begin
		#800000;
		n_mismatch++;
		end_sim();
	end
endmodule
